/* File: rtl/ufr_regs.svh */
`ifndef UFR_REGS_SVH
`define UFR_REGS_SVH

// ********************************************************
// register byte addresses
// ********************************************************
`define UFR_TX_LEVEL_ADDR 32'h50001080
`define UFR_RX_LEVEL_ADDR 32'h50001084
`define UFR_SOFT_RESET_ADDR 32'h50001088
`define UFR_RTS_MIRROR_ADDR 32'h5000108C
`define UFR_MODEM_CTRL_ADDR 32'h500010A0
`define UFR_FIFO_CTRL_ADDR 32'h500010A4

// ********************************************************
// field positions
// ********************************************************
`define UFR_SRR_PORT_RST 0
`define UFR_SRR_RX_CLR 1
`define UFR_SRR_TX_CLR 2
`define UFR_SRTS_RTS 0
`define UFR_MCR_RTS 1
`define UFR_MCR_LOOP 4
`define UFR_MCR_AFCE 5
`define UFR_FCR_EN 0
`define UFR_FCR_RX_CLR 1
`define UFR_FCR_TX_CLR 2
`define UFR_FCR_THR_LSB 8
`define UFR_FCR_THR_MSB 12

// ********************************************************
// reset values and counts
// ********************************************************
`define UFR_LEVEL_RST 5'h00
`define UFR_FCR_THR_RST 5'h08
`define UFR_RESP_OKAY 2'h0
`define UFR_RESP_SLVERR 2'h2
`define UFR_RST_SYNC_STAGES 2

`endif

/* File: rtl/ufr_pkg.sv */
package ufr_pkg;

  typedef logic [4:0] ufr_level_type;

  typedef struct packed {
    logic push;
    logic pop;
  } ufr_fifo_event_type;

  typedef struct packed {
    logic loopback;
    logic autoFlow;
    logic rts;
  } ufr_modem_ctrl_type;

  typedef struct packed {
    logic [4:0] rxThreshold;
    logic fifoEnable;
  } ufr_fifo_ctrl_type;

  typedef enum logic [2:0] {
    SEL_TX_LEVEL,
    SEL_RX_LEVEL,
    SEL_SOFT_RESET,
    SEL_RTS_MIRROR,
    SEL_MODEM_CTRL,
    SEL_FIFO_CTRL,
    SEL_NONE
  } ufr_reg_sel_type;

endpackage

/* File: rtl/ufr_reset_sync.sv */
`timescale 1ns/1ps

// asserts at once on the request pulse, releases on clock edges
module ufr_reset_sync #(
  parameter int STAGES = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic assertReq,
  output logic syncRst_n
);
  import ufr_pkg::*;

  logic [STAGES-1:0] chain_ff;

  // assertReq is itself a flop output, so it cannot glitch
  always_ff @(posedge clock or posedge assertReq) begin
    if (assertReq) begin
      chain_ff <= '0;
    end else if (!rst_n) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], 1'b1};
    end
  end

  assign syncRst_n = chain_ff[STAGES-1];

endmodule // ufr_reset_sync

/* File: rtl/ufr_top.sv */
`timescale 1ns/1ps
`include "ufr_regs.svh"

module ufr_top #(
  parameter int ADDR_W = 32,
  parameter int FIFO_DEPTH = 16,
  parameter bit AUTO_FLOW_HW_OPTION = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ufr_pkg::ufr_fifo_event_type txFifoEvent,
  input wire ufr_pkg::ufr_fifo_event_type rxFifoEvent,
  output logic txFifoClear,
  output logic rxFifoClear,
  output logic portReset_n,
  output logic requestToSend_n,
  output logic loopbackRts
);
  import ufr_pkg::*;

  localparam ufr_level_type DEPTH_LEVEL = 5'(FIFO_DEPTH);

  // ********************************************************
  // shared decode
  // ********************************************************
  function automatic ufr_reg_sel_type decodeReg(input logic [ADDR_W-1:0] addr);
    logic [31:0] word;
    word = 32'({addr[ADDR_W-1:2], 2'b00});
    case (word)
      `UFR_TX_LEVEL_ADDR: decodeReg = SEL_TX_LEVEL;
      `UFR_RX_LEVEL_ADDR: decodeReg = SEL_RX_LEVEL;
      `UFR_SOFT_RESET_ADDR: decodeReg = SEL_SOFT_RESET;
      `UFR_RTS_MIRROR_ADDR: decodeReg = SEL_RTS_MIRROR;
      `UFR_MODEM_CTRL_ADDR: decodeReg = SEL_MODEM_CTRL;
      `UFR_FIFO_CTRL_ADDR: decodeReg = SEL_FIFO_CTRL;
      default: decodeReg = SEL_NONE;
    endcase
  endfunction

  // a bit takes part in a write only if its byte lane is enabled
  function automatic logic laneOn(input logic [3:0] strb, input int pos);
    laneOn = strb[pos / 8];
  endfunction

  // ********************************************************
  // declarations
  // ********************************************************
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic doWrite;
  ufr_reg_sel_type wrSel;
  ufr_reg_sel_type rdSel;
  logic [31:0] nxt_rdata;
  logic wrSoftReset;
  logic wrRtsMirror;
  logic wrModemCtrl;
  logic wrFifoCtrl;
  logic portRstReq_ff;
  logic portRstSync_n;
  logic ctrlClear;
  logic fifoClr_ff [2];
  ufr_level_type level_ff [2];
  ufr_fifo_event_type fifoEvent [2];
  ufr_modem_ctrl_type modemCtrl_ff;
  ufr_fifo_ctrl_type fifoCtrl_ff;
  logic autoFlowActive;
  logic rxAboveThreshold;
  logic rtsN_ff;
  logic loopRts_ff;

  // ********************************************************
  // write channel
  // ********************************************************
  // address and data may arrive in either order; each is held until both are in
  assign doWrite = !awready_ff && !wready_ff && !bvalid_ff;
  assign wrSel = decodeReg(awAddr_ff);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      awAddr_ff <= s_axi_awaddr;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wready_ff <= 1'b1;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `UFR_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wrSel == SEL_NONE) ? `UFR_RESP_SLVERR : `UFR_RESP_OKAY;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign wrSoftReset = doWrite && (wrSel == SEL_SOFT_RESET);
  assign wrRtsMirror = doWrite && (wrSel == SEL_RTS_MIRROR);
  assign wrModemCtrl = doWrite && (wrSel == SEL_MODEM_CTRL);
  assign wrFifoCtrl = doWrite && (wrSel == SEL_FIFO_CTRL);

  // ********************************************************
  // read channel
  // ********************************************************
  assign rdSel = decodeReg(s_axi_araddr);

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (rdSel)
      SEL_TX_LEVEL: nxt_rdata = 32'(level_ff[0]);
      SEL_RX_LEVEL: nxt_rdata = 32'(level_ff[1]);
      SEL_SOFT_RESET: nxt_rdata = 32'h00000000;
      SEL_RTS_MIRROR: nxt_rdata[`UFR_SRTS_RTS] = modemCtrl_ff.rts;
      SEL_MODEM_CTRL: begin
        nxt_rdata[`UFR_MCR_RTS] = modemCtrl_ff.rts;
        nxt_rdata[`UFR_MCR_LOOP] = modemCtrl_ff.loopback;
        nxt_rdata[`UFR_MCR_AFCE] = modemCtrl_ff.autoFlow;
      end
      SEL_FIFO_CTRL: begin
        nxt_rdata[`UFR_FCR_EN] = fifoCtrl_ff.fifoEnable;
        nxt_rdata[`UFR_FCR_THR_MSB:`UFR_FCR_THR_LSB] = fifoCtrl_ff.rxThreshold;
      end
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `UFR_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= (rdSel == SEL_NONE) ? `UFR_RESP_SLVERR : `UFR_RESP_OKAY;
      rdata_ff <= nxt_rdata;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // ********************************************************
  // port soft reset
  // ********************************************************
  // the bus slave is kept out of this reset so the write response is not lost
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      portRstReq_ff <= 1'b0;
    end else begin
      portRstReq_ff <= wrSoftReset && laneOn(wStrb_ff, `UFR_SRR_PORT_RST) &&
                       wData_ff[`UFR_SRR_PORT_RST];
    end
  end

  ufr_reset_sync #(
    .STAGES(`UFR_RST_SYNC_STAGES)
  ) u_port_reset (
    .clock(clock),
    .rst_n(rst_n),
    .assertReq(portRstReq_ff),
    .syncRst_n(portRstSync_n)
  );

  // one clock here, so this single synchroniser releases every part of the port
  assign ctrlClear = !rst_n || !portRstSync_n;

  // ********************************************************
  // fifo clear pulses
  // ********************************************************
  // one cycle only: the bits never hold a value software could see
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      fifoClr_ff[0] <= 1'b0;
      fifoClr_ff[1] <= 1'b0;
    end else begin
      fifoClr_ff[0] <= (wrSoftReset && laneOn(wStrb_ff, `UFR_SRR_TX_CLR) &&
                        wData_ff[`UFR_SRR_TX_CLR]) ||
                       (wrFifoCtrl && laneOn(wStrb_ff, `UFR_FCR_TX_CLR) &&
                        wData_ff[`UFR_FCR_TX_CLR]);
      fifoClr_ff[1] <= (wrSoftReset && laneOn(wStrb_ff, `UFR_SRR_RX_CLR) &&
                        wData_ff[`UFR_SRR_RX_CLR]) ||
                       (wrFifoCtrl && laneOn(wStrb_ff, `UFR_FCR_RX_CLR) &&
                        wData_ff[`UFR_FCR_RX_CLR]);
    end
  end

  // ********************************************************
  // fifo level counters
  // ********************************************************
  assign fifoEvent[0] = txFifoEvent;
  assign fifoEvent[1] = rxFifoEvent;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_level
      // a clear wins over a push or pop in the same cycle, as the fifo is emptied
      always_ff @(posedge clock) begin
        if (ctrlClear || fifoClr_ff[i]) begin
          level_ff[i] <= `UFR_LEVEL_RST;
        end else if (fifoEvent[i].push && !fifoEvent[i].pop &&
                     level_ff[i] < DEPTH_LEVEL) begin
          level_ff[i] <= level_ff[i] + 5'h01;
        end else if (fifoEvent[i].pop && !fifoEvent[i].push &&
                     level_ff[i] != 5'h00) begin
          level_ff[i] <= level_ff[i] - 5'h01;
        end
      end
    end
  endgenerate

  // ********************************************************
  // modem control
  // ********************************************************
  // one storage bit behind both the mirror and the modem control register
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      modemCtrl_ff.rts <= 1'b0;
    end else if (wrRtsMirror && laneOn(wStrb_ff, `UFR_SRTS_RTS)) begin
      modemCtrl_ff.rts <= wData_ff[`UFR_SRTS_RTS];
    end else if (wrModemCtrl && laneOn(wStrb_ff, `UFR_MCR_RTS)) begin
      modemCtrl_ff.rts <= wData_ff[`UFR_MCR_RTS];
    end
  end

  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      modemCtrl_ff.loopback <= 1'b0;
      modemCtrl_ff.autoFlow <= 1'b0;
    end else if (wrModemCtrl && laneOn(wStrb_ff, `UFR_MCR_LOOP)) begin
      modemCtrl_ff.loopback <= wData_ff[`UFR_MCR_LOOP];
      modemCtrl_ff.autoFlow <= wData_ff[`UFR_MCR_AFCE];
    end
  end

  // ********************************************************
  // fifo control
  // ********************************************************
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      fifoCtrl_ff.fifoEnable <= 1'b0;
    end else if (wrFifoCtrl && laneOn(wStrb_ff, `UFR_FCR_EN)) begin
      fifoCtrl_ff.fifoEnable <= wData_ff[`UFR_FCR_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      fifoCtrl_ff.rxThreshold <= `UFR_FCR_THR_RST;
    end else if (wrFifoCtrl && laneOn(wStrb_ff, `UFR_FCR_THR_LSB)) begin
      fifoCtrl_ff.rxThreshold <= wData_ff[`UFR_FCR_THR_MSB:`UFR_FCR_THR_LSB];
    end
  end

  // ********************************************************
  // request to send
  // ********************************************************
  assign autoFlowActive = AUTO_FLOW_HW_OPTION && modemCtrl_ff.autoFlow &&
                          fifoCtrl_ff.fifoEnable;
  assign rxAboveThreshold = level_ff[1] > fifoCtrl_ff.rxThreshold;

  // loopback outranks flow gating; the pin then stays idle whatever the bit says
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      rtsN_ff <= 1'b1;
    end else if (modemCtrl_ff.loopback) begin
      rtsN_ff <= 1'b1;
    end else if (autoFlowActive && rxAboveThreshold) begin
      rtsN_ff <= 1'b1;
    end else begin
      rtsN_ff <= !modemCtrl_ff.rts;
    end
  end

  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      loopRts_ff <= 1'b0;
    end else begin
      loopRts_ff <= modemCtrl_ff.loopback && modemCtrl_ff.rts;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign txFifoClear = fifoClr_ff[0];
  assign rxFifoClear = fifoClr_ff[1];
  assign portReset_n = portRstSync_n;
  assign requestToSend_n = rtsN_ff;
  assign loopbackRts = loopRts_ff;

endmodule // ufr_top

/* File: tb/ufr_top_asserts.sv */
`timescale 1ns/1ps

module ufr_top_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic txFifoClear,
  input wire logic rxFifoClear,
  input wire logic portReset_n,
  input wire logic requestToSend_n,
  input wire logic loopbackRts
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_TX_CLR_ONE: assert property (txFifoClear |=> !txFifoClear)
    else $error("tx clear longer than one cycle");
  AST_RX_CLR_ONE: assert property (rxFifoClear |=> !rxFifoClear)
    else $error("rx clear longer than one cycle");
  AST_TX_CLR_CAUSE: assert property (txFifoClear |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("tx clear without a write");
  AST_RX_CLR_CAUSE: assert property (rxFifoClear |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("rx clear without a write");
  AST_PORT_RST_CAUSE: assert property ($fell(portReset_n) |-> s_axi_bvalid)
    else $error("port reset without a write");
  AST_PORT_RST_FREE: assert property ($fell(portReset_n) |=> !portReset_n ##[1:4] portReset_n)
    else $error("port reset release out of time");
  AST_PORT_RST_QUIET: assert property ($fell(portReset_n) |-> ##3 requestToSend_n && !loopbackRts)
    else $error("modem outputs not cleared by port reset");
  AST_LOOP_RTS_HIGH: assert property (loopbackRts |-> requestToSend_n)
    else $error("rts driven during loopback");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken under a pending response");
endmodule // ufr_top_asserts

/* File: tb/ufr_fifo_model.sv */
`timescale 1ns/1ps

// random fifo traffic; counts follow the same saturation as a real fifo
module ufr_fifo_model import ufr_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic runTx,
  input wire logic runRx,
  input wire logic clrTx,
  input wire logic clrRx,
  output ufr_pkg::ufr_fifo_event_type txEv,
  output ufr_pkg::ufr_fifo_event_type rxEv,
  output logic [4:0] txCnt,
  output logic [4:0] rxCnt
);
  integer seed = 32'h7312;
  logic [31:0] r;
  initial begin
    txEv = '0;
    rxEv = '0;
    txCnt = 5'h00;
    rxCnt = 5'h00;
  end
  function automatic logic [4:0] step(logic [4:0] c, ufr_fifo_event_type e);
    if (e.push && !e.pop && c < 5'(DEPTH)) return c + 5'h01;
    if (e.pop && !e.push && c != 5'h00) return c - 5'h01;
    return c;
  endfunction
  always @(posedge clock) begin
    r = $random(seed);
    txCnt <= clrTx ? 5'h00 : step(txCnt, txEv);
    rxCnt <= clrRx ? 5'h00 : step(rxCnt, rxEv);
    txEv <= '{push: runTx & (r[0] | r[1]), pop: runTx & r[2] & r[3]};
    rxEv <= '{push: runRx & (r[4] | r[5]), pop: runRx & r[6] & r[7]};
  end
endmodule // ufr_fifo_model

/* File: tb/ufr_top_tb.sv */
`timescale 1ns/1ps
`include "ufr_regs.svh"

module ufr_top_tb;
  import ufr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  ufr_fifo_event_type txEv, rxEv;
  logic txFifoClear, rxFifoClear, portReset_n, requestToSend_n, loopbackRts;
  logic runTx = 1'b0, runRx = 1'b0, clrTx = 1'b0, clrRx = 1'b0;
  logic [4:0] txCnt, rxCnt;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int mismatches = 0;
  int n_compared = 0;
  int txClrSeen = 0;
  int rxClrSeen = 0;

  ufr_top uut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .txFifoEvent(txEv), .rxFifoEvent(rxEv),
    .txFifoClear(txFifoClear), .rxFifoClear(rxFifoClear), .portReset_n(portReset_n),
    .requestToSend_n(requestToSend_n), .loopbackRts(loopbackRts));
  ufr_fifo_model far (.clock(clock), .runTx(runTx), .runRx(runRx), .clrTx(clrTx),
    .clrRx(clrRx), .txEv(txEv), .rxEv(rxEv), .txCnt(txCnt), .rxCnt(rxCnt));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ********************************************************
  // bus master: one transfer at a time, waits bounded
  // ********************************************************
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge clock);
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic axi_read(input logic [31:0] a, input logic [33:0] exp);
    bit done;
    done = 1'b0;
    @(posedge clock);
    rq.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      stop_test();
    end
  endtask

  // responses are matched against the oldest note of the driver
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    // a stuck clear would be counted more than once
    if (txFifoClear) txClrSeen++;
    if (rxFifoClear) rxClrSeen++;
  end

  task automatic traffic(input bit tx, input bit rx);
    runTx <= tx;
    runRx <= rx;
    repeat (40) @(posedge clock);
    runTx <= 1'b0;
    runRx <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic forget();
    clrTx <= 1'b1;
    clrRx <= 1'b1;
    @(posedge clock);
    clrTx <= 1'b0;
    clrRx <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    axi_read(`UFR_TX_LEVEL_ADDR, 34'h0);
    axi_read(`UFR_RX_LEVEL_ADDR, 34'h0);
    axi_read(`UFR_SOFT_RESET_ADDR, 34'h0);
    axi_read(`UFR_RTS_MIRROR_ADDR, 34'h0);
    chk("rts_n", 34'h1, {33'h0, requestToSend_n});
    axi_write(32'h500010C0, 32'hFF, `UFR_RESP_SLVERR);
    axi_read(32'h500010C0, 34'h200000000);
    // ********************************************************
    // levels and fifo clears
    // ********************************************************
    traffic(1'b1, 1'b1);
    axi_write(`UFR_TX_LEVEL_ADDR, 32'h1F, `UFR_RESP_OKAY);
    axi_read(`UFR_TX_LEVEL_ADDR, {29'h0, txCnt});
    axi_read(`UFR_RX_LEVEL_ADDR, {29'h0, rxCnt});
    axi_write(`UFR_SOFT_RESET_ADDR, 32'h0, `UFR_RESP_OKAY);
    axi_read(`UFR_TX_LEVEL_ADDR, {29'h0, txCnt});
    // lane 0 disabled: the clear bit must not take part in the write
    s_axi_wstrb <= 4'hE;
    axi_write(`UFR_SOFT_RESET_ADDR, 32'h4, `UFR_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(`UFR_TX_LEVEL_ADDR, {29'h0, txCnt});
    axi_write(`UFR_SOFT_RESET_ADDR, 32'h4, `UFR_RESP_OKAY);
    axi_read(`UFR_TX_LEVEL_ADDR, 34'h0);
    axi_read(`UFR_RX_LEVEL_ADDR, {29'h0, rxCnt});
    axi_read(`UFR_SOFT_RESET_ADDR, 34'h0);
    chk("tx_clr", 34'h1, 34'(txClrSeen));
    axi_write(`UFR_SOFT_RESET_ADDR, 32'h2, `UFR_RESP_OKAY);
    axi_read(`UFR_RX_LEVEL_ADDR, 34'h0);
    chk("rx_clr", 34'h1, 34'(rxClrSeen));
    forget();
    // ********************************************************
    // request to send: mirror, auto flow, loopback
    // ********************************************************
    axi_write(`UFR_RTS_MIRROR_ADDR, 32'h1, `UFR_RESP_OKAY);
    axi_read(`UFR_MODEM_CTRL_ADDR, 34'h2);
    chk("rts_n", 34'h0, {33'h0, requestToSend_n});
    axi_write(`UFR_MODEM_CTRL_ADDR, 32'h0, `UFR_RESP_OKAY);
    axi_read(`UFR_RTS_MIRROR_ADDR, 34'h0);
    chk("rts_n", 34'h1, {33'h0, requestToSend_n});
    axi_write(`UFR_FIFO_CTRL_ADDR, 32'h1, `UFR_RESP_OKAY);
    axi_write(`UFR_MODEM_CTRL_ADDR, 32'h22, `UFR_RESP_OKAY);
    traffic(1'b0, 1'b1);
    // the pin lags the level by one edge
    @(posedge clock);
    chk("rts_n", {33'h0, rxCnt > 5'h00}, {33'h0, requestToSend_n});
    // threshold 31 and both fifo control clears in one write
    axi_write(`UFR_FIFO_CTRL_ADDR, 32'h1F07, `UFR_RESP_OKAY);
    axi_read(`UFR_RX_LEVEL_ADDR, 34'h0);
    chk("tx_clr", 34'h2, 34'(txClrSeen));
    chk("rx_clr", 34'h2, 34'(rxClrSeen));
    chk("rts_n", 34'h0, {33'h0, requestToSend_n});
    axi_write(`UFR_MODEM_CTRL_ADDR, 32'h12, `UFR_RESP_OKAY);
    @(posedge clock);
    chk("rts_n", 34'h1, {33'h0, requestToSend_n});
    chk("loop", 34'h1, {33'h0, loopbackRts});
    // ********************************************************
    // whole port reset
    // ********************************************************
    traffic(1'b1, 1'b0);
    axi_write(`UFR_SOFT_RESET_ADDR, 32'h1, `UFR_RESP_OKAY);
    repeat (8) @(posedge clock);
    forget();
    chk("port_n", 34'h1, {33'h0, portReset_n});
    chk("loop", 34'h0, {33'h0, loopbackRts});
    axi_read(`UFR_TX_LEVEL_ADDR, 34'h0);
    axi_read(`UFR_RX_LEVEL_ADDR, 34'h0);
    axi_read(`UFR_MODEM_CTRL_ADDR, 34'h0);
    repeat (2) @(posedge clock);
    stop_test();
  end
endmodule // ufr_top_tb

bind ufr_top ufr_top_asserts chk_i (.clock(clock), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .txFifoClear(txFifoClear), .rxFifoClear(rxFifoClear), .portReset_n(portReset_n),
  .requestToSend_n(requestToSend_n), .loopbackRts(loopbackRts));
